// >>> rtl/pcsb_top.sv
// Function
// - Cfg/data pair per bit: hi-z input, pull-up input, drive low, drive high.
// - Each bidirectional port has config, output data and pin-level read words.
// - Port G data bits 6 and 7 always read back as zero.
// - Writing one to port G data bit 7 enters halt.
// - Writing one to port G data bit 6 with bit 7 zero enters idle.
// - Port G config bit 6 selects the alternate serial clock phase.
// - Port G config bit 7 adds restart delay after halt in RC mode.
// - RC option: G7 is an input and its rising edge ends halt.
// - Crystal option: G7 output is gated by xtal_opt, which is sampled before the strap synchroniser settles and so stays 0.
// - G1 is a dedicated output for the watchdog fault indication.
// - Port G: five configurable pins, G6 input only, G1 and G7 dedicated.
// - Port D outputs are forced high while reset is low.
// - Instruction cycle clock is the input clock divided by ten.
// - Port I is an eight-bit hi-z input port feeding converter inputs.
// - Port L pins give multi-input wakeup; L4 and L5 feed timer 2.
// - Port G pins carry interrupt, timer 1 and serial alternate inputs.
// - Programming mode turns G0, G2, G3, G6 into strobe and enable inputs.
// - Every bit of ports C and L, and G0 and G2 to G5, is configured independently.
`timescale 1ns/1ps
`include "pcsb_map.svh"
module pcsb_top
	import pcsb_pkg::*;
(
	// Clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// APB slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	// Ports C, G, L, I pads (slot order C, G, L, I)
	input  wire logic [3:0][7:0] io_pin_in,
	output logic      [3:0][7:0] io_pin_out,
	output logic      [3:0][7:0] io_pin_oe_n,
	output logic      [3:0][7:0] io_pin_pullup,
	// Port D pads
	output logic      [7:0]      port_d_out,
	// Clock pins and option straps
	input  wire logic            osc_in_pin,
	input  wire logic            xtal_opt_strap,
	input  wire logic            prog_mode_pin,
	// Core side
	input  wire logic            watchdog_fault,
	input  wire logic            idle_timer_wake,
	output logic                 instr_tick,
	output logic                 core_run,
	output logic                 halt_mode,
	output logic                 idle_mode,
	output logic                 sk_alt_phase,
	output logic                 halt_restart_delay_en,
	// Alternate pin functions
	output logic                 ext_irq_in,
	output logic                 timer1_capture_b,
	output logic                 timer1_io_a,
	output logic                 serial_clock_pin,
	output logic                 serial_data_in,
	output logic                 timer2_in_a,
	output logic                 timer2_in_b,
	output logic                 multi_input_wakeup,
	output logic      [7:0]      adc_in,
	// Programming mode strobes
	output logic                 prog_ale,
	output logic                 prog_wr,
	output logic                 prog_rd,
	output logic                 mux_enable_pin
);
	localparam logic [3:0]  DIV_LAST = 4'(`PCSB_ICLK_DIV - 1);
	localparam logic [11:0] DLY_LAST = 12'(`PCSB_RESTART_CYC - 1);

	pcsb_top_s r;
	pcsb_top_s next_r;

	pcsb_port_if pif [`PCSB_NPORT] ();

	logic       setup;
	logic       wr_acc;
	logic       hit;
	logic [7:0] wb;
	logic       prog;
	logic       l_edge;
	logic       g7_rise;
	logic       halt_exit;
	logic [7:0] lvl_c;
	logic [7:0] lvl_g;
	logic [7:0] lvl_l;
	logic [7:0] lvl_i;
	logic [7:0] cfg_g;

	assign setup  = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign wb     = pwdata[7:0];
	assign prog   = r.mlvl[`PCSB_MS_PROG];
	assign lvl_c  = pif[`PCSB_PC].level;
	assign lvl_g  = pif[`PCSB_PG].level;
	assign lvl_l  = pif[`PCSB_PL].level;
	assign lvl_i  = pif[`PCSB_PI].level;
	assign cfg_g  = pif[`PCSB_PG].cfg;

	always_comb begin
		case (paddr)
			`PCSB_OFS_C_DATA, `PCSB_OFS_C_CFG, `PCSB_OFS_C_IN,
			`PCSB_OFS_G_DATA, `PCSB_OFS_G_CFG, `PCSB_OFS_G_IN,
			`PCSB_OFS_L_DATA, `PCSB_OFS_L_CFG, `PCSB_OFS_L_IN,
			`PCSB_OFS_D_DATA, `PCSB_OFS_I_IN, `PCSB_OFS_STATUS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// Register writes into the port instances
	always_comb begin
		for (int p = 0; p < `PCSB_NPORT; p++) begin
		end
	end

	generate
		for (genvar p = 0; p < `PCSB_NPORT; p++) begin : g_port
			localparam logic [7:0] OFS_DATA = 8'(p * 12);
			localparam logic [7:0] OFS_CFG  = 8'(p * 12 + 4);
			// Port I has no writable words
			assign pif[p].cfg_we = (p != `PCSB_PI) && wr_acc && paddr == OFS_CFG;
			assign pif[p].dat_we = (p != `PCSB_PI) && wr_acc && paddr == OFS_DATA;
			assign pif[p].wdata  = wb;
			pcsb_io_port u_port (
				.pclk       (pclk),
				.presetn    (presetn),
				.pif        (pif[p]),
				.pin_in     (io_pin_in[p]),
				.pin_out    (io_pin_out[p]),
				.pin_oe_n   (io_pin_oe_n[p]),
				.pin_pullup (io_pin_pullup[p])
			);
		end
	endgenerate

	// Pin role overrides
	assign pif[`PCSB_PC].ovr_mask  = 8'h00;
	assign pif[`PCSB_PC].ovr_drive = 8'h00;
	assign pif[`PCSB_PC].ovr_val   = 8'h00;
	assign pif[`PCSB_PL].ovr_mask  = 8'h00;
	assign pif[`PCSB_PL].ovr_drive = 8'h00;
	assign pif[`PCSB_PL].ovr_val   = 8'h00;
	assign pif[`PCSB_PI].ovr_mask  = 8'hff;
	assign pif[`PCSB_PI].ovr_drive = 8'h00;
	assign pif[`PCSB_PI].ovr_val   = 8'h00;
	// G1, G6, G7 fixed; strobe pins forced to inputs in programming mode
	assign pif[`PCSB_PG].ovr_mask  = `PCSB_G_FIXED_MASK | (prog ? `PCSB_G_PROG_MASK : 8'h00);
	always_comb begin
		pif[`PCSB_PG].ovr_drive = 8'h00;
		pif[`PCSB_PG].ovr_val   = 8'h00;
		pif[`PCSB_PG].ovr_drive[`PCSB_G_WATCHDOG_FAULT_OUT_PIN] = 1'b1;
		pif[`PCSB_PG].ovr_val[`PCSB_G_WATCHDOG_FAULT_OUT_PIN]   = r.wd_out;
		pif[`PCSB_PG].ovr_drive[`PCSB_G_OSC_PIN]   = r.xtal_opt;
		pif[`PCSB_PG].ovr_val[`PCSB_G_OSC_PIN]     = r.osc_out;
	end

	assign l_edge    = |(lvl_l ^ r.l_prev);
	assign g7_rise   = ~r.xtal_opt & lvl_g[`PCSB_G_OSC_PIN] & ~r.g7_prev;
	assign halt_exit = l_edge | g7_rise;

	always_comb begin
		next_r = r;
		// APB read data is captured in the setup cycle
		if (setup) begin
			next_r.rd_err = ~hit;
			next_r.prdata = '0;
			case (paddr)
				`PCSB_OFS_C_DATA: next_r.prdata[7:0] = pif[`PCSB_PC].dat;
				`PCSB_OFS_C_CFG:  next_r.prdata[7:0] = pif[`PCSB_PC].cfg;
				`PCSB_OFS_C_IN:   next_r.prdata[7:0] = lvl_c;
				`PCSB_OFS_G_DATA: next_r.prdata[7:0] = pif[`PCSB_PG].dat & `PCSB_G_DATA_RD_MASK;
				`PCSB_OFS_G_CFG:  next_r.prdata[7:0] = cfg_g;
				`PCSB_OFS_G_IN:   next_r.prdata[7:0] = lvl_g;
				`PCSB_OFS_L_DATA: next_r.prdata[7:0] = pif[`PCSB_PL].dat;
				`PCSB_OFS_L_CFG:  next_r.prdata[7:0] = pif[`PCSB_PL].cfg;
				`PCSB_OFS_L_IN:   next_r.prdata[7:0] = lvl_l;
				`PCSB_OFS_D_DATA: next_r.prdata[7:0] = r.port_d;
				`PCSB_OFS_I_IN:   next_r.prdata[7:0] = lvl_i;
				`PCSB_OFS_STATUS: begin
					next_r.prdata[`PCSB_ST_HALT]    = r.pwr == PCSB_HALT;
					next_r.prdata[`PCSB_ST_IDLE]    = r.pwr == PCSB_IDLE;
					next_r.prdata[`PCSB_ST_RESTART] = r.pwr == PCSB_RESTART;
					next_r.prdata[`PCSB_ST_XTAL]    = r.xtal_opt;
					next_r.prdata[`PCSB_ST_PROG]    = prog;
				end
				default: next_r.prdata = '0;
			endcase
		end
		if (wr_acc && paddr == `PCSB_OFS_D_DATA) begin
			next_r.port_d = wb;
		end

		// Three-stage synchronisers for clock pin and straps
		next_r.ms1 = {xtal_opt_strap, prog_mode_pin, osc_in_pin};
		next_r.ms2 = r.ms1;
		next_r.ms3 = r.ms2;
		for (int b = 0; b < 3; b++) begin
			if (r.ms2[b] == r.ms3[b]) begin
				next_r.mlvl[b] = r.ms3[b];
			end
		end
		// Oscillator option is sampled for the first three cycles after reset, before the synchroniser settles
		if (r.strap_cnt != `PCSB_STRAP_WAIT) begin
			next_r.strap_cnt = r.strap_cnt + 2'd1;
			next_r.xtal_opt  = r.mlvl[`PCSB_MS_XTAL];
		end
		next_r.osc_out = ~r.mlvl[`PCSB_MS_OSC];
		next_r.wd_out  = watchdog_fault;
		next_r.g7_prev = lvl_g[`PCSB_G_OSC_PIN];
		next_r.l_prev  = lvl_l;
		next_r.wake    = l_edge;

		// Power mode sequencing
		case (r.pwr)
			PCSB_RUN: begin
				if (wr_acc && paddr == `PCSB_OFS_G_DATA && wb[`PCSB_G_HALT_BIT]) begin
					next_r.pwr = PCSB_HALT;
				end else if (wr_acc && paddr == `PCSB_OFS_G_DATA && wb[`PCSB_G_IDLE_BIT]) begin
					next_r.pwr = PCSB_IDLE;
				end
			end
			PCSB_HALT: begin
				if (halt_exit) begin
					if (!r.xtal_opt && cfg_g[`PCSB_G_HALT_RESTART_DELAY_EN_BIT]) begin
						next_r.pwr     = PCSB_RESTART;
						next_r.dly_cnt = DLY_LAST;
					end else begin
						next_r.pwr = PCSB_RUN;
					end
				end
			end
			PCSB_IDLE: begin
				if (l_edge || idle_timer_wake) begin
					next_r.pwr = PCSB_RUN;
				end
			end
			PCSB_RESTART: begin
				if (r.dly_cnt == '0) begin
					next_r.pwr = PCSB_RUN;
				end else begin
					next_r.dly_cnt = r.dly_cnt - 12'd1;
				end
			end
			default: next_r.pwr = PCSB_RUN;
		endcase

		// Instruction clock runs only while the core runs
		next_r.iclk_tick = 1'b0;
		if (r.pwr == PCSB_RUN) begin
			if (r.div_cnt == DIV_LAST) begin
				next_r.div_cnt   = '0;
				next_r.iclk_tick = 1'b1;
			end else begin
				next_r.div_cnt = r.div_cnt + 4'd1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{port_d: `PCSB_D_RST, pwr: PCSB_RUN, default: '0};
		end else begin
			r <= next_r;
		end
	end

	assign prdata  = r.prdata;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & r.rd_err;

	assign port_d_out            = r.port_d;
	assign instr_tick            = r.iclk_tick;
	assign core_run              = r.pwr == PCSB_RUN;
	assign halt_mode             = r.pwr == PCSB_HALT;
	assign idle_mode             = r.pwr == PCSB_IDLE;
	assign sk_alt_phase          = cfg_g[`PCSB_G_ALTSK_BIT];
	assign halt_restart_delay_en = cfg_g[`PCSB_G_HALT_RESTART_DELAY_EN_BIT];

	assign ext_irq_in         = lvl_g[`PCSB_G_EXTIRQ_PIN] & ~prog;
	assign timer1_capture_b   = lvl_g[`PCSB_G_T1B_PIN];
	assign timer1_io_a        = lvl_g[`PCSB_G_T1A_PIN];
	assign serial_clock_pin   = lvl_g[`PCSB_G_SK_PIN];
	assign serial_data_in     = lvl_g[`PCSB_G_SI_PIN];
	assign timer2_in_a        = lvl_l[`PCSB_L_T2A_PIN];
	assign timer2_in_b        = lvl_l[`PCSB_L_T2B_PIN];
	assign multi_input_wakeup = r.wake;
	assign adc_in             = lvl_i;

	assign prog_ale       = prog & lvl_g[`PCSB_G_EXTIRQ_PIN];
	assign prog_wr        = prog & lvl_g[`PCSB_G_T1B_PIN];
	assign prog_rd        = prog & lvl_g[`PCSB_G_T1A_PIN];
	assign mux_enable_pin = prog & lvl_g[`PCSB_G_SI_PIN];
endmodule

// >>> rtl/pcsb_map.svh
`ifndef PCSB_MAP_SVH
`define PCSB_MAP_SVH

// Byte addresses of the register words
`define PCSB_OFS_C_DATA     8'h00
`define PCSB_OFS_C_CFG      8'h04
`define PCSB_OFS_C_IN       8'h08
`define PCSB_OFS_G_DATA     8'h0c
`define PCSB_OFS_G_CFG      8'h10
`define PCSB_OFS_G_IN       8'h14
`define PCSB_OFS_L_DATA     8'h18
`define PCSB_OFS_L_CFG      8'h1c
`define PCSB_OFS_L_IN       8'h20
`define PCSB_OFS_D_DATA     8'h24
`define PCSB_OFS_I_IN       8'h28
`define PCSB_OFS_STATUS     8'h2c

// Port slots in the generate loop
`define PCSB_NPORT          4
`define PCSB_PC             0
`define PCSB_PG             1
`define PCSB_PL             2
`define PCSB_PI             3

// Reset values
`define PCSB_PORT_RST       8'h00
`define PCSB_D_RST          8'hff

// Port G special bits and pin roles, port L timer 2 pins
`define PCSB_G_HALT_BIT     7
`define PCSB_G_IDLE_BIT     6
`define PCSB_G_HALT_RESTART_DELAY_EN_BIT   7
`define PCSB_G_ALTSK_BIT    6
`define PCSB_G_DATA_RD_MASK 8'h3f
`define PCSB_G_EXTIRQ_PIN   0
`define PCSB_G_WATCHDOG_FAULT_OUT_PIN    1
`define PCSB_G_T1B_PIN      2
`define PCSB_G_T1A_PIN      3
`define PCSB_G_SK_PIN       5
`define PCSB_G_SI_PIN       6
`define PCSB_G_OSC_PIN      7
`define PCSB_G_FIXED_MASK   8'hc2
`define PCSB_G_PROG_MASK    8'h4d
`define PCSB_L_T2A_PIN      4
`define PCSB_L_T2B_PIN      5

// Status word bits
`define PCSB_ST_HALT        0
`define PCSB_ST_IDLE        1
`define PCSB_ST_RESTART     2
`define PCSB_ST_XTAL        3
`define PCSB_ST_PROG        4

// Misc synchroniser slots
`define PCSB_MS_OSC         0
`define PCSB_MS_PROG        1
`define PCSB_MS_XTAL        2

// Timing counts
`define PCSB_ICLK_DIV       10
`define PCSB_RESTART_CYC    256
`define PCSB_STRAP_WAIT     2'd3

`endif

// >>> rtl/pcsb_pkg.sv
package pcsb_pkg;

	typedef enum logic [1:0] {
		PCSB_RUN,
		PCSB_HALT,
		PCSB_IDLE,
		PCSB_RESTART
	} pcsb_pwr_e;

	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] dat;
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
		logic [7:0] lvl;
		logic [7:0] pad_out;
		logic [7:0] pad_oe_n;
		logic [7:0] pad_pu;
	} pcsb_port_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        rd_err;
		logic [7:0]  port_d;
		logic [3:0]  div_cnt;
		logic        iclk_tick;
		pcsb_pwr_e   pwr;
		logic [11:0] dly_cnt;
		logic        xtal_opt;
		logic [1:0]  strap_cnt;
		logic [2:0]  ms1;
		logic [2:0]  ms2;
		logic [2:0]  ms3;
		logic [2:0]  mlvl;
		logic        g7_prev;
		logic [7:0]  l_prev;
		logic        wake;
		logic        osc_out;
		logic        wd_out;
	} pcsb_top_s;

endpackage

// >>> rtl/pcsb_port_if.sv
`timescale 1ns/1ps
interface pcsb_port_if;
	logic       cfg_we;
	logic       dat_we;
	logic [7:0] wdata;
	logic [7:0] cfg;
	logic [7:0] dat;
	logic [7:0] level;
	logic [7:0] ovr_mask;
	logic [7:0] ovr_drive;
	logic [7:0] ovr_val;

	modport ctrl (output cfg_we, output dat_we, output wdata, output ovr_mask, output ovr_drive,
		output ovr_val, input cfg, input dat, input level);
	modport port (input cfg_we, input dat_we, input wdata, input ovr_mask, input ovr_drive,
		input ovr_val, output cfg, output dat, output level);
endinterface

// >>> rtl/pcsb_io_port.sv
`timescale 1ns/1ps
`include "pcsb_map.svh"
module pcsb_io_port
	import pcsb_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Register side
	pcsb_port_if.port       pif,
	// Pad side
	input  wire logic [7:0] pin_in,
	output logic      [7:0] pin_out,
	output logic      [7:0] pin_oe_n,
	output logic      [7:0] pin_pullup
);
	pcsb_port_s r;
	pcsb_port_s next_r;

	always_comb begin
		next_r = r;
		if (pif.cfg_we) begin
			next_r.cfg = pif.wdata;
		end
		if (pif.dat_we) begin
			next_r.dat = pif.wdata;
		end
		next_r.s1 = pin_in;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		// Level follows once two settled stages agree
		for (int b = 0; b < 8; b++) begin
			if (r.s2[b] == r.s3[b]) begin
				next_r.lvl[b] = r.s3[b];
			end
		end
		// Pad drive from the cfg/data pair unless a pin role overrides it
		for (int b = 0; b < 8; b++) begin
			if (pif.ovr_mask[b]) begin
				next_r.pad_out[b]  = pif.ovr_val[b];
				next_r.pad_oe_n[b] = ~pif.ovr_drive[b];
				next_r.pad_pu[b]   = 1'b0;
			end else begin
				next_r.pad_out[b]  = next_r.dat[b];
				next_r.pad_oe_n[b] = ~next_r.cfg[b];
				next_r.pad_pu[b]   = ~next_r.cfg[b] & next_r.dat[b];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{cfg: `PCSB_PORT_RST, dat: `PCSB_PORT_RST, pad_oe_n: 8'hff, default: '0};
		end else begin
			r <= next_r;
		end
	end

	assign pif.cfg   = r.cfg;
	assign pif.dat   = r.dat;
	assign pif.level = r.lvl;
	assign pin_out    = r.pad_out;
	assign pin_oe_n   = r.pad_oe_n;
	assign pin_pullup = r.pad_pu;
endmodule

// >>> verification/pcsb_pads_model.sv
`timescale 1ns/1ps
module pcsb_pads_model (
	// Clock
	input  wire logic [0:0]      pclk,
	// Device pad drive
	input  wire logic [3:0][7:0] pin_out,
	input  wire logic [3:0][7:0] pin_oe_n,
	input  wire logic [3:0][7:0] pin_pullup,
	// Board drive
	input  wire logic [3:0][7:0] ext_en,
	input  wire logic [3:0][7:0] ext_val,
	// Levels seen by the device
	output logic      [3:0][7:0] pin_in
);
	logic [31:0] flt = 32'h0;

	// Floating pads toggle every cycle, so the level filter keeps their last settled level
	always @(posedge pclk) begin
		flt <= ~flt;
	end
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
		| (pin_oe_n & ~ext_en & (pin_pullup | flt));
endmodule

// >>> verification/pcsb_top_monitor.sv
`timescale 1ns/1ps
module pcsb_top_monitor (
	// Clock and reset
	input wire logic            pclk,
	input wire logic            presetn,
	// Bus
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [7:0]      paddr,
	input wire logic [31:0]     pwdata,
	input wire logic [31:0]     prdata,
	// Pads and core
	input wire logic [3:0][7:0] io_pin_out,
	input wire logic [7:0]      port_d_out,
	input wire logic            watchdog_fault,
	input wire logic            instr_tick,
	input wire logic            core_run,
	input wire logic            halt_mode,
	input wire logic            idle_mode,
	input wire logic            sk_alt_phase,
	input wire logic            halt_restart_delay_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_gd_wr;
		s_acc ##0 (pwrite && paddr == 8'h0c);
	endsequence
	sequence s_gc_wr;
		s_acc ##0 (pwrite && paddr == 8'h10);
	endsequence

	property p_upper;
		s_acc |-> prdata[31:8] == 24'h0;
	endproperty
	property p_gd_rd;
		s_acc ##0 (!pwrite && paddr == 8'h0c) |-> prdata[7:6] == 2'b00;
	endproperty
	property p_halt;
		s_gd_wr ##0 (pwdata[7] && core_run) |=> halt_mode && !core_run;
	endproperty
	property p_idle;
		s_gd_wr ##0 (pwdata[7:6] == 2'b01 && core_run) |=> idle_mode && !halt_mode;
	endproperty
	property p_gcfg;
		s_gc_wr |=> sk_alt_phase == $past(pwdata[6]) && halt_restart_delay_en == $past(pwdata[7]);
	endproperty
	property p_d_rst;
		$rose(presetn) |-> port_d_out == 8'hff;
	endproperty
	property p_tick;
		instr_tick |=> !instr_tick [*8];
	endproperty
	property p_wd;
		io_pin_out[1][1] == $past(watchdog_fault, 2);
	endproperty

	a_upper: assert property (p_upper) else $error("upper read bits not zero");
	a_gd_rd: assert property (p_gd_rd) else $error("port G data bits 6 7 read nonzero");
	a_halt: assert property (p_halt) else $error("halt not entered");
	a_idle: assert property (p_idle) else $error("idle not entered");
	a_gcfg: assert property (p_gcfg) else $error("port G config special bits wrong");
	a_d_rst: assert property (p_d_rst) else $error("port D not high out of reset");
	a_tick: assert property (p_tick) else $error("instruction ticks too close");
	a_wd: assert property (p_wd) else $error("G1 does not follow watchdog fault");
endmodule

bind pcsb_top pcsb_top_monitor pcsb_top_monitor_inst (.*);

// >>> verification/pcsb_top_tb.sv
`timescale 1ns/1ps
`include "pcsb_map.svh"
module pcsb_top_tb;
	logic            pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]      paddr = 8'h0;
	logic [31:0]     pwdata = 32'h0, prdata, rdat;
	logic            pready, pslverr, rerr, mw;
	logic [3:0][7:0] io_pin_in, io_pin_out, io_pin_oe_n, io_pin_pullup;
	logic [3:0][7:0] ext_en = {8'hff, 8'hf7, 8'hf7, 8'hf7}, ext_val = {8'ha5, 8'h04, 8'h04, 8'h04};
	logic [7:0]      port_d_out, adc_in;
	logic            osc_in_pin = 0, xtal_opt_strap = 0, prog_mode_pin = 0, watchdog_fault = 0, idle_timer_wake = 0;
	logic            instr_tick, core_run, halt_mode, idle_mode, sk_alt_phase, halt_restart_delay_en;
	logic            ext_irq_in, timer1_capture_b, timer1_io_a, serial_clock_pin, serial_data_in;
	logic            timer2_in_a, timer2_in_b, multi_input_wakeup, prog_ale, prog_wr, prog_rd, mux_enable_pin;
	int              n_errors = 0, n_compared = 0, cnt;

	pcsb_top pcsb_top_inst (.*);
	pcsb_pads_model pcsb_pads_model_inst (.pclk(pclk), .pin_out(io_pin_out), .pin_oe_n(io_pin_oe_n),
		.pin_pullup(io_pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(io_pin_in));

	initial begin
		forever #2.5 pclk = ~pclk;
	end

	task automatic w(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic summarize();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#25000;
		n_errors++;
		summarize();
	end

	initial begin
		w(3);
		presetn <= 1'b1;
		w(6);
		while (instr_tick !== 1'b1) w(1);
		w(1);
		cnt = 1;
		while (instr_tick !== 1'b1) begin
			w(1);
			cnt++;
		end
		chk(cnt, 10);
		apb(1'b0, 8'h30, 8'h0);
		chk({rerr, rdat[30:0]}, 32'h8000_0000);
		// Bits 2..5 take the four set-ups on each of C, G, L
		for (int p = 0; p < 3; p++) begin
			apb(1'b1, `PCSB_OFS_C_CFG + 8'(12 * p), 8'h30);
			apb(1'b1, `PCSB_OFS_C_DATA + 8'(12 * p), 8'h28);
			apb(1'b0, `PCSB_OFS_C_CFG + 8'(12 * p), 8'h0);
			chk(rdat, 32'h30);
		end
		w(8);
		for (int p = 0; p < 3; p++) begin
			chk({io_pin_oe_n[p][5:2], io_pin_pullup[p][5:2], io_pin_out[p][5:4]}, 10'b0011_0010_10);
			apb(1'b0, `PCSB_OFS_C_IN + 8'(12 * p), 8'h0);
			chk(rdat, 32'h2c);
		end
		chk({timer1_capture_b, timer1_io_a, serial_clock_pin, serial_data_in, ext_irq_in}, 5'b11100);
		chk({timer2_in_a, timer2_in_b}, 2'b01);
		chk({io_pin_oe_n[3], adc_in}, 16'hffa5);
		chk({io_pin_oe_n[1][7:6], io_pin_oe_n[1][1]}, 3'b110);
		watchdog_fault <= 1'b1;
		w(3);
		chk(io_pin_out[1][1], 1'b1);
		watchdog_fault <= 1'b0;
		apb(1'b1, `PCSB_OFS_G_DATA, 8'ha8);
		w(1);
		chk({halt_mode, core_run}, 2'b10);
		apb(1'b0, `PCSB_OFS_G_DATA, 8'h0);
		chk(rdat, 32'h28);
		apb(1'b0, `PCSB_OFS_STATUS, 8'h0);
		chk(rdat[4:0], 5'b00001);
		mw = 1'b0;
		ext_val[2][2] <= 1'b0;
		while (core_run !== 1'b1) begin
			w(1);
			mw |= multi_input_wakeup;
		end
		chk(mw, 1'b1);
		apb(1'b1, `PCSB_OFS_G_CFG, 8'hf0);
		w(1);
		chk({halt_restart_delay_en, sk_alt_phase}, 2'b11);
		apb(1'b1, `PCSB_OFS_G_DATA, 8'ha8);
		w(2);
		chk(halt_mode, 1'b1);
		ext_val[1][7] <= 1'b1;
		cnt = 0;
		while (core_run !== 1'b1) begin
			w(1);
			cnt++;
		end
		chk(cnt >= `PCSB_RESTART_CYC && cnt < `PCSB_RESTART_CYC + 14, 1'b1);
		apb(1'b1, `PCSB_OFS_G_DATA, 8'h68);
		w(1);
		chk({idle_mode, halt_mode}, 2'b10);
		cnt = 0;
		repeat (12) begin
			w(1);
			cnt += int'(instr_tick);
		end
		chk(cnt, 0);
		idle_timer_wake <= 1'b1;
		w(1);
		idle_timer_wake <= 1'b0;
		w(3);
		chk(core_run, 1'b1);
		prog_mode_pin <= 1'b1;
		ext_val[1][0] <= 1'b1;
		w(8);
		chk({prog_ale, ext_irq_in, mux_enable_pin}, 3'b100);
		prog_mode_pin <= 1'b0;
		apb(1'b1, `PCSB_OFS_D_DATA, 8'h5a);
		w(1);
		chk(port_d_out, 8'h5a);
		presetn <= 1'b0;
		w(1);
		chk(port_d_out, `PCSB_D_RST);
		presetn <= 1'b1;
		w(6);
		apb(1'b0, `PCSB_OFS_C_CFG, 8'h0);
		chk(rdat, 32'h0);
		summarize();
	end
endmodule
